//--- rtl/mis_move_unit.sv
// What this block does
// - decode store, load, selector store/load, direct-offset and immediate copy forms
// - source and destination share one size: byte, word, doubleword or quadword
// - copy into the code segment register raises invalid opcode fault
// - protected segment load fills hidden descriptor part after validation
// - descriptor fetched from global or local table entry the selector names
// - null selector loads into data and extra segments without fault or checks
// - memory reference through a null data segment faults outside 64-bit mode, no access made
// - after stack segment load, interrupts held off until next instruction ends
// - in a run of stack segment loads every other one defers interrupts, starting with the first
// - selector copied to a general register lands in its low 16 bits
// - upper bits of that general register are cleared
// - 64-bit mode defaults to 32 bits, wide bit gives 64, extension bit more regs
// - direct offset is segment-base relative, width set by address size
// - with any extension prefix byte fields never pick legacy high-byte registers
// - wide immediate-to-register-or-memory form sign-extends its 32-bit immediate
// - null selector into stack segment raises protection fault, code zero
// - stack segment checks: limit, privileges, writable data; absent gives stack fault
// - data segment checks: limit, data or readable code; absent gives not-present
// - data or nonconforming code faults when both privileges exceed descriptor's
// - memory destination in non-writable segment raises protection fault, code zero
// - effective address past a segment limit faults, code zero: stack fault through SS, else protection fault
module mis_move_unit
  import mis_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // instruction issue
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  modrm_i,
  input  wire logic        rex_present_i,
  input  wire logic        wide_operand_prefix_bit_i,
  input  wire logic        register_extension_prefix_bit_i,
  input  wire logic        rex_b_i,
  input  wire logic        opsize16_i,
  input  wire mis_size_t   addr_size_i,
  input  wire logic        mode64_i,
  input  wire logic        prot_mode_i,
  input  wire logic [1:0]  cpl_i,
  input  wire logic [63:0] src_data_i,
  input  wire logic [63:0] imm_i,
  input  wire logic [63:0] mem_ea_i,
  input  wire logic [2:0]  mem_seg_i,
  // descriptor tables
  input  wire logic [31:0] gdt_base_i,
  input  wire logic [15:0] gdt_limit_i,
  input  wire logic [31:0] ldt_base_i,
  input  wire logic [15:0] ldt_limit_i,
  input  wire logic        desc_valid_i,
  input  wire logic        desc_present_i,
  input  wire logic        desc_s_i,
  input  wire logic [3:0]  desc_type_i,
  input  wire logic [1:0]  desc_dpl_i,
  input  wire logic [31:0] desc_base_i,
  input  wire logic [19:0] desc_limit_i,
  input  wire logic        desc_g_i,
  // results
  output logic             ready_o,
  output logic             done_o,
  output mis_form_t        form_o,
  output mis_size_t        size_o,
  output logic             wr_gpr_o,
  output logic             wr_mem_o,
  output logic [3:0]       dst_idx_o,
  output logic             dst_hi_byte_o,
  output logic [63:0]      wr_data_o,
  output logic [63:0]      mem_addr_o,
  output logic             fault_o,
  output mis_fault_t       fault_kind_o,
  output logic [15:0]      fault_code_o,
  output logic             desc_req_o,
  output logic [31:0]      desc_addr_o,
  output logic             int_inhibit_o
);

  function automatic mis_form_t form_of(input logic [7:0] op, input logic [2:0] rf);
    mis_form_t f;
    f = F_NONE;
    if (op == OPC_MR8 || op == OPC_MR) f = F_MR;
    else if (op == OPC_RM8 || op == OPC_RM) f = F_RM;
    else if (op == OPC_SST) f = F_SST;
    else if (op == OPC_SLD) f = F_SLD;
    else if (op == OPC_FD8 || op == OPC_FD) f = F_FD;
    else if (op == OPC_TD8 || op == OPC_TD) f = F_TD;
    else if (op[7:4] == OPC_OI_HI) f = F_OI;
    else if ((op == OPC_MI8 || op == OPC_MI) && rf == MI_REG) f = F_MI;
    return f;
  endfunction

  function automatic logic [63:0] size_mask(input mis_size_t s);
    case (s)
      SZ8:     return MASK8;
      SZ16:    return MASK16;
      SZ32:    return MASK32;
      default: return MASK64;
    endcase
  endfunction

  // returns {high byte, register index}
  function automatic logic [4:0] gpr_sel(input logic x, input logic [2:0] c,
                                          input logic byte_op, input logic rex);
    if (byte_op && !rex && c[HI_BYTE_BIT]) return {1'b1, 2'b00, c[1:0]};
    return {1'b0, x, c};
  endfunction

  mis_state_t  state_reg, state_next;
  logic [15:0] seg_sel_reg [SEG_NUM];
  logic [15:0] seg_sel_next [SEG_NUM];
  logic [31:0] seg_base_reg [SEG_NUM];
  logic [31:0] seg_base_next [SEG_NUM];
  logic [31:0] seg_lim_reg [SEG_NUM];
  logic [31:0] seg_lim_next [SEG_NUM];
  logic        seg_wr_reg [SEG_NUM];
  logic        seg_wr_next [SEG_NUM];
  logic        seg_nul_reg [SEG_NUM];
  logic        seg_nul_next [SEG_NUM];
  logic [2:0]  pend_seg_reg, pend_seg_next;
  logic [15:0] pend_sel_reg, pend_sel_next;
  logic        ready_reg, ready_next, done_reg, done_next, inh_reg, inh_next;
  logic        wr_gpr_reg, wr_gpr_next, wr_mem_reg, wr_mem_next;
  logic        hi_reg, hi_next, fault_reg, fault_next, dreq_reg, dreq_next;
  mis_form_t   form_reg, form_next;
  mis_size_t   size_reg, size_next;
  mis_fault_t  kind_reg, kind_next, kind;
  logic [3:0]  dst_reg, dst_next;
  logic [63:0] data_reg, data_next, addr_reg, addr_next;
  logic [15:0] code_reg, code_next, code;
  logic [31:0] daddr_reg, daddr_next;
  // decode results
  logic [2:0]  reg_f, seg_ix, sr_ix;
  logic        mod_reg, byte_op, mem_op, mem_wr, gpr_wr, mem_nul, mem_over, acc;
  mis_form_t   form;
  mis_size_t   opsz;
  logic [4:0]  dst;
  logic [63:0] ea_m, mem_addr, res;
  logic [15:0] sel, sst_sel, tbl_lim, idx_end;
  logic [31:0] tbl_base, lim_exp;
  logic        sel_nul, is_code, is_rw, is_conf;
  // load control
  logic        fin, load, ld_wr, ld_nul;
  logic [2:0]  ld_seg;
  logic [31:0] ld_base, ld_lim;

  assign acc = instr_valid_i && state_reg == ST_IDLE;

  // operand decode; all of it is combinational off the issue and descriptor inputs and the segment registers
  always_comb
  begin
    reg_f   = modrm_i[5:3];
    mod_reg = modrm_i[7:6] == MOD_REG;
    form    = form_of(opcode_i, reg_f);
    // selector moves are never byte wide, so 8c never picks a high-byte register
    byte_op = (form == F_OI) ? !opcode_i[OI_WIDE_BIT]
            : (form != F_SST && form != F_SLD && !opcode_i[0]);
    sr_ix   = (reg_f > SEG_GS) ? SEG_DS : reg_f;
    seg_ix  = (mem_seg_i > SEG_GS) ? SEG_DS : mem_seg_i;
    if (byte_op && form != F_SST && form != F_SLD) opsz = SZ8;
    else if (form == F_SLD || (form == F_SST && !mod_reg)) opsz = SZ16;
    else if (mode64_i && wide_operand_prefix_bit_i) opsz = SZ64;
    else if (opsize16_i) opsz = SZ16;
    else opsz = SZ32;
    case (form)
      F_RM:    dst = gpr_sel(register_extension_prefix_bit_i, reg_f, byte_op, rex_present_i);
      F_OI:    dst = gpr_sel(rex_b_i, opcode_i[2:0], byte_op, rex_present_i);
      F_FD:    dst = 5'h00;
      default: dst = gpr_sel(rex_b_i, modrm_i[2:0], byte_op, rex_present_i);
    endcase
    mem_op = form == F_FD || form == F_TD || (form != F_OI && form != F_NONE && !mod_reg);
    mem_wr = form == F_TD || ((form == F_MR || form == F_SST || form == F_MI) && !mod_reg);
    gpr_wr = !mem_wr && form != F_SLD && form != F_TD;
    sst_sel = seg_sel_reg[sr_ix];
    case (form)
      F_SST:   res = {48'h0, sst_sel};
      F_OI:    res = imm_i;
      F_MI:    res = (opsz == SZ64) ? {{32{imm_i[IMM_SIGN]}}, imm_i[31:0]} : imm_i;
      default: res = src_data_i;
    endcase
    // offsets are cut to the address size, then added to the segment base
    ea_m     = mem_ea_i & size_mask(addr_size_i);
    mem_addr = {32'h0, seg_base_reg[seg_ix]} + ea_m;
    mem_nul  = prot_mode_i && !mode64_i && seg_nul_reg[seg_ix];
    // flat 64-bit mode has no limits; only the start address is compared
    mem_over = !mode64_i && ea_m > {32'h0, seg_lim_reg[seg_ix]};
    sel      = src_data_i[15:0];
    sel_nul  = sel[15:SEL_TI] == '0;
    tbl_base = sel[SEL_TI] ? ldt_base_i : gdt_base_i;
    tbl_lim  = sel[SEL_TI] ? ldt_limit_i : gdt_limit_i;
    idx_end  = {sel[15:SEL_IDX], 3'b111};
    is_code  = desc_type_i[DT_CODE];
    is_rw    = desc_type_i[DT_RW];
    is_conf  = desc_type_i[DT_CONF];
    lim_exp  = desc_g_i ? {desc_limit_i, PAGE_FILL} : {12'h0, desc_limit_i};
  end

  // execution: one instruction at a time, segment loads may wait for a descriptor
  always_comb
  begin
    state_next    = state_reg;
    seg_sel_next  = seg_sel_reg;
    seg_base_next = seg_base_reg;
    seg_lim_next  = seg_lim_reg;
    seg_wr_next   = seg_wr_reg;
    seg_nul_next  = seg_nul_reg;
    pend_seg_next = pend_seg_reg;
    pend_sel_next = pend_sel_reg;
    form_next = form_reg;
    size_next = size_reg;
    dst_next  = dst_reg;
    hi_next   = hi_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    kind_next = kind_reg;
    code_next = code_reg;
    daddr_next = daddr_reg;
    done_next = 1'b0;
    fault_next = 1'b0;
    dreq_next = 1'b0;
    wr_gpr_next = 1'b0;
    wr_mem_next = 1'b0;
    kind = FLT_NONE;
    code = 16'h0000;
    fin = 1'b0;
    load = 1'b0;
    ld_seg = sr_ix;
    ld_base = {12'h0, sel, 4'h0};
    ld_lim = LIM_RST;
    ld_wr = 1'b1;
    ld_nul = 1'b0;
    case (state_reg)
      ST_IDLE:
        if (instr_valid_i)
        begin
          fin = 1'b1;
          form_next = form;
          size_next = opsz;
          dst_next  = dst[3:0];
          hi_next   = dst[4];
          data_next = res & size_mask(opsz);
          addr_next = mem_addr;
          if (form == F_NONE || (form == F_SLD && reg_f == SEG_CS) || reg_f > SEG_GS && (form == F_SLD || form == F_SST))
            kind = FLT_UD;
          else if (mem_op && mem_nul)
            kind = FLT_GP;
          else if (mem_op && mem_over)
            kind = (seg_ix == SEG_SS) ? FLT_SS : FLT_GP;
          else if (mem_wr && prot_mode_i && !seg_wr_reg[seg_ix])
            kind = FLT_GP;
          else if (form == F_SLD)
          begin
            load = 1'b1;
            pend_seg_next = sr_ix;
            pend_sel_next = sel;
            if (!prot_mode_i)
              ld_nul = 1'b0;
            else if (sel_nul)
            begin
              if (sr_ix == SEG_SS) kind = FLT_GP;
              ld_nul = 1'b1;
            end
            else if (idx_end > tbl_lim)
            begin
              kind = FLT_GP;
              code = {sel[15:SEL_TI], 2'b00};
            end
            else
            begin
              fin = 1'b0;
              load = 1'b0;
              dreq_next = 1'b1;
              daddr_next = tbl_base + {16'h0, sel[15:SEL_IDX], 3'b000};
              state_next = ST_WAIT;
            end
          end
        end
      ST_WAIT:
        if (desc_valid_i)
        begin
          fin = 1'b1;
          load = 1'b1;
          ld_seg = pend_seg_reg;
          code = {pend_sel_reg[15:SEL_TI], 2'b00};
          ld_base = desc_base_i;
          ld_lim = lim_exp;
          ld_wr = !is_code && is_rw;
          state_next = ST_IDLE;
          if (pend_seg_reg == SEG_SS)
          begin
            if (pend_sel_reg[1:0] != cpl_i || !desc_s_i || is_code || !is_rw || desc_dpl_i != cpl_i)
              kind = FLT_GP;
            else if (!desc_present_i)
              kind = FLT_SS;
          end
          else if (!desc_s_i || (is_code && !is_rw))
            kind = FLT_GP;
          else if ((!is_code || !is_conf) && pend_sel_reg[1:0] > desc_dpl_i && cpl_i > desc_dpl_i)
            kind = FLT_GP;
          else if (!desc_present_i)
            kind = FLT_NP;
        end
      default:
        state_next = ST_IDLE;
    endcase
    if (fin)
    begin
      done_next  = 1'b1;
      fault_next = kind != FLT_NONE;
      kind_next  = kind;
      code_next  = code;
      wr_gpr_next = kind == FLT_NONE && gpr_wr && state_reg == ST_IDLE;
      wr_mem_next = kind == FLT_NONE && mem_wr && state_reg == ST_IDLE;
    end
    // a faulting load never touches the segment state
    if (load && kind == FLT_NONE)
    begin
      seg_sel_next[ld_seg]  = (state_reg == ST_WAIT) ? pend_sel_reg : sel;
      seg_base_next[ld_seg] = ld_base;
      seg_lim_next[ld_seg]  = ld_lim;
      seg_wr_next[ld_seg]   = ld_wr;
      seg_nul_next[ld_seg]  = ld_nul;
    end
    // the window ends with the next instruction; a second stack load does not rearm it
    inh_next = inh_reg;
    if (fin) inh_next = 1'b0;
    if (fin && load && kind == FLT_NONE && ld_seg == SEG_SS && !inh_reg)
      inh_next = 1'b1;
    ready_next = state_next == ST_IDLE;
  end

  // state registers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < SEG_NUM; i++)
      begin
        seg_sel_reg[i]  <= SEL_RST;
        seg_base_reg[i] <= BASE_RST;
        seg_lim_reg[i]  <= LIM_RST;
        seg_wr_reg[i]   <= 1'b1;
        seg_nul_reg[i]  <= 1'b0;
      end
      pend_seg_reg <= SEG_DS;
      pend_sel_reg <= SEL_RST;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      inh_reg <= 1'b0;
      wr_gpr_reg <= 1'b0;
      wr_mem_reg <= 1'b0;
      hi_reg <= 1'b0;
      fault_reg <= 1'b0;
      dreq_reg <= 1'b0;
      form_reg <= F_NONE;
      size_reg <= SZ8;
      kind_reg <= FLT_NONE;
      dst_reg <= 4'h0;
      data_reg <= 64'h0;
      addr_reg <= 64'h0;
      code_reg <= 16'h0;
      daddr_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      seg_sel_reg  <= seg_sel_next;
      seg_base_reg <= seg_base_next;
      seg_lim_reg  <= seg_lim_next;
      seg_wr_reg   <= seg_wr_next;
      seg_nul_reg  <= seg_nul_next;
      pend_seg_reg <= pend_seg_next;
      pend_sel_reg <= pend_sel_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      inh_reg <= inh_next;
      wr_gpr_reg <= wr_gpr_next;
      wr_mem_reg <= wr_mem_next;
      hi_reg <= hi_next;
      fault_reg <= fault_next;
      dreq_reg <= dreq_next;
      form_reg <= form_next;
      size_reg <= size_next;
      kind_reg <= kind_next;
      dst_reg <= dst_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      code_reg <= code_next;
      daddr_reg <= daddr_next;
    end
  end

  // outputs straight from flops
  assign ready_o = ready_reg;
  assign done_o = done_reg;
  assign form_o = form_reg;
  assign size_o = size_reg;
  assign wr_gpr_o = wr_gpr_reg;
  assign wr_mem_o = wr_mem_reg;
  assign dst_idx_o = dst_reg;
  assign dst_hi_byte_o = hi_reg;
  assign wr_data_o = data_reg;
  assign mem_addr_o = addr_reg;
  assign fault_o = fault_reg;
  assign fault_kind_o = kind_reg;
  assign fault_code_o = code_reg;
  assign desc_req_o = dreq_reg;
  assign desc_addr_o = daddr_reg;
  assign int_inhibit_o = inh_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  chk_cs_load_ud: assert property (acc && opcode_i == OPC_SLD && reg_f == SEG_CS
    |=> done_o && fault_o && fault_kind_o == FLT_UD) else $error("cs load not refused");
  chk_sst_low_bits: assert property (acc && form == F_SST && mod_reg && kind == FLT_NONE
    |=> wr_data_o[15:0] == $past(sst_sel)) else $error("selector not in low bits");
  chk_sst_upper_zero: assert property (acc && form == F_SST && mod_reg
    |=> wr_data_o[63:16] == '0) else $error("selector store not zero extended");
  chk_imm_sign_ext: assert property (acc && form == F_MI && opsz == SZ64
    |=> wr_data_o == {{32{$past(imm_i[IMM_SIGN])}}, $past(imm_i[31:0])})
    else $error("immediate not sign extended");
  chk_default_size: assert property (acc && mode64_i && form == F_MR && !byte_op
    |=> size_o == ($past(wide_operand_prefix_bit_i) ? SZ64 : ($past(opsize16_i) ? SZ16 : SZ32)))
    else $error("wrong operand size in 64-bit mode");
  chk_ss_null_gp: assert property (acc && prot_mode_i && form == F_SLD && reg_f == SEG_SS
    && sel_nul && !mem_op |=> fault_o && fault_kind_o == FLT_GP && fault_code_o == '0)
    else $error("null stack load not faulted");
  chk_null_data_ok: assert property (acc && prot_mode_i && form == F_SLD && reg_f == SEG_DS
    && sel_nul && !mem_op |=> done_o && !fault_o ##0 seg_nul_reg[SEG_DS])
    else $error("null data load faulted");
  chk_null_ref_gp: assert property (acc && mem_op && mem_nul && form != F_NONE
    && !(form == F_SLD && reg_f == SEG_CS) && reg_f <= SEG_GS
    |=> fault_o && fault_kind_o == FLT_GP && !wr_mem_o && !wr_gpr_o)
    else $error("null segment reference not faulted");
  // inhibit may only fall together with the next completion pulse
  chk_inhibit_hold: assert property (int_inhibit_o ##1 !done_o |-> int_inhibit_o)
    else $error("inhibit dropped early");
  chk_inhibit_end: assert property (int_inhibit_o ##1 done_o |-> !int_inhibit_o)
    else $error("inhibit rearmed by later stack load");
  chk_fault_keeps_seg: assert property (state_reg == ST_WAIT && desc_valid_i
    && !desc_present_i |=> fault_o ##0 $stable(seg_base_reg[pend_seg_reg]))
    else $error("faulting load changed segment");
  chk_desc_wait: assert property (desc_req_o |-> !ready_o && !done_o ##1 !done_o)
    else $error("descriptor request without wait");

endmodule

//--- rtl/mis_pkg.sv
package mis_pkg;
  // opcode values of the copy instruction
  localparam logic [7:0] OPC_MR8  = 8'h88;
  localparam logic [7:0] OPC_MR   = 8'h89;
  localparam logic [7:0] OPC_RM8  = 8'h8a;
  localparam logic [7:0] OPC_RM   = 8'h8b;
  localparam logic [7:0] OPC_SST  = 8'h8c;
  localparam logic [7:0] OPC_SLD  = 8'h8e;
  localparam logic [7:0] OPC_FD8  = 8'ha0;
  localparam logic [7:0] OPC_FD   = 8'ha1;
  localparam logic [7:0] OPC_TD8  = 8'ha2;
  localparam logic [7:0] OPC_TD   = 8'ha3;
  localparam logic [7:0] OPC_MI8  = 8'hc6;
  localparam logic [7:0] OPC_MI   = 8'hc7;
  localparam logic [3:0] OPC_OI_HI = 4'hb;
  localparam int         OI_WIDE_BIT = 3;
  localparam logic [2:0] MI_REG   = 3'h0;
  localparam logic [1:0] MOD_REG  = 2'h3;
  localparam int         HI_BYTE_BIT = 2;
  // segment register numbers
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_GS = 3'h5;
  localparam int         SEG_NUM = 6;
  // selector and descriptor fields
  localparam int          SEL_TI  = 2;
  localparam int          SEL_IDX = 3;
  localparam int          DT_CODE = 3;
  localparam int          DT_CONF = 2;
  localparam int          DT_RW   = 1;
  localparam int          IMM_SIGN = 31;
  localparam logic [11:0] PAGE_FILL = 12'hfff;
  localparam logic [31:0] LIM_RST  = 32'h0000ffff;
  localparam logic [31:0] BASE_RST = 32'h00000000;
  localparam logic [15:0] SEL_RST  = 16'h0000;
  // operand masks per size
  localparam logic [63:0] MASK8  = 64'h0000_0000_0000_00ff;
  localparam logic [63:0] MASK16 = 64'h0000_0000_0000_ffff;
  localparam logic [63:0] MASK32 = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] MASK64 = 64'hffff_ffff_ffff_ffff;
  typedef enum logic [1:0] {SZ8 = 2'b00, SZ16 = 2'b01, SZ32 = 2'b10, SZ64 = 2'b11} mis_size_t;
  typedef enum logic [3:0] {
    F_NONE = 4'b0000, F_MR = 4'b0001, F_RM = 4'b0010, F_SST = 4'b0011, F_SLD = 4'b0100,
    F_FD = 4'b0101, F_TD = 4'b0110, F_OI = 4'b0111, F_MI = 4'b1000
  } mis_form_t;
  typedef enum logic [2:0] {
    FLT_NONE = 3'b000, FLT_UD = 3'b001, FLT_GP = 3'b010, FLT_SS = 3'b011, FLT_NP = 3'b100
  } mis_fault_t;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_WAIT = 1'b1} mis_state_t;
endpackage

//--- tb/test_mis_move_unit.sv
module test_mis_move_unit;
  import mis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic flt; mis_fault_t kind; logic [15:0] code; logic wr; logic [63:0] data;} mis_exp_t;

  // design inputs
  logic core_clk_i = 1'b0, srst_i = 1'b1, instr_valid_i = 1'b0;
  logic [7:0] opcode_i = 8'h00, modrm_i = 8'h00;
  logic rex_present_i = 1'b0, wide_operand_prefix_bit_i = 1'b0, register_extension_prefix_bit_i = 1'b0, rex_b_i = 1'b0, opsize16_i = 1'b0;
  mis_size_t addr_size_i = SZ32;
  logic mode64_i = 1'b0, prot_mode_i = 1'b0;
  logic [1:0] cpl_i = 2'h0, desc_dpl_i = 2'h0;
  logic [63:0] src_data_i = 64'h0, imm_i = 64'h0, mem_ea_i = 64'h10;
  logic [2:0] mem_seg_i = 3'h3;
  logic [31:0] gdt_base_i = 32'h0, ldt_base_i = 32'h0, desc_base_i = 32'h0;
  logic [15:0] gdt_limit_i = 16'h00ff, ldt_limit_i = 16'h0;
  logic desc_valid_i = 1'b0, desc_present_i = 1'b1, desc_s_i = 1'b1, desc_g_i = 1'b0;
  logic [3:0] desc_type_i = 4'h2;
  logic [19:0] desc_limit_i = 20'h0;
  // design outputs
  logic ready_o, done_o, wr_gpr_o, wr_mem_o, dst_hi_byte_o, fault_o, desc_req_o, int_inhibit_o;
  mis_form_t form_o;
  mis_size_t size_o;
  mis_fault_t fault_kind_o;
  logic [3:0] dst_idx_o;
  logic [63:0] wr_data_o, mem_addr_o;
  logic [15:0] fault_code_o;
  logic [31:0] desc_addr_o;
  // bench state
  mis_exp_t exp_q[$];
  int failures = 0;
  int comparisons = 0;
  integer seed = 32'h4941;

  mis_move_unit mis_move_unit_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .modrm_i(modrm_i), .rex_present_i(rex_present_i), .wide_operand_prefix_bit_i(wide_operand_prefix_bit_i),
    .register_extension_prefix_bit_i(register_extension_prefix_bit_i), .rex_b_i(rex_b_i), .opsize16_i(opsize16_i), .addr_size_i(addr_size_i),
    .mode64_i(mode64_i), .prot_mode_i(prot_mode_i), .cpl_i(cpl_i), .src_data_i(src_data_i),
    .imm_i(imm_i), .mem_ea_i(mem_ea_i), .mem_seg_i(mem_seg_i), .gdt_base_i(gdt_base_i),
    .gdt_limit_i(gdt_limit_i), .ldt_base_i(ldt_base_i), .ldt_limit_i(ldt_limit_i),
    .desc_valid_i(desc_valid_i), .desc_present_i(desc_present_i), .desc_s_i(desc_s_i),
    .desc_type_i(desc_type_i), .desc_dpl_i(desc_dpl_i), .desc_base_i(desc_base_i),
    .desc_limit_i(desc_limit_i), .desc_g_i(desc_g_i), .ready_o(ready_o), .done_o(done_o),
    .form_o(form_o), .size_o(size_o), .wr_gpr_o(wr_gpr_o), .wr_mem_o(wr_mem_o),
    .dst_idx_o(dst_idx_o), .dst_hi_byte_o(dst_hi_byte_o), .wr_data_o(wr_data_o),
    .mem_addr_o(mem_addr_o), .fault_o(fault_o), .fault_kind_o(fault_kind_o),
    .fault_code_o(fault_code_o), .desc_req_o(desc_req_o), .desc_addr_o(desc_addr_o),
    .int_inhibit_o(int_inhibit_o)
  );

  // 8 ns period
  always #4 core_clk_i = ~core_clk_i;

  task automatic close_out;
    if (failures == 0 && comparisons > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] want, input string what);
    comparisons++;
    if (got !== want)
    begin
      $display("BAD %0t %s", $time, what);
      failures++;
    end
  endtask

  function automatic mis_exp_t ex(logic f, mis_fault_t k, logic [15:0] c, logic w, logic [63:0] d);
    mis_exp_t e;
    e = '{flt: f, kind: k, code: c, wr: w, data: d};
    return e;
  endfunction

  // bounded wait for a flag; a hang counts as a failure and ends the run
  task automatic wait_for(ref logic flag);
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk_i);
      if (flag === 1'b1)
        break;
    end
    if (n == 20)
    begin
      $display("BAD %0t handshake timeout", $time);
      failures++;
      close_out();
    end
  endtask

  // one instruction; dsc means a descriptor fetch is answered mid-way
  task automatic issue(input logic [7:0] opc, input logic [7:0] mrm, input logic w,
                       input logic [63:0] src, input mis_exp_t e, input logic dsc);
    exp_q.push_back(e);
    opcode_i <= opc;
    modrm_i <= mrm;
    wide_operand_prefix_bit_i <= w;
    src_data_i <= src;
    instr_valid_i <= 1'b1;
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    if (dsc)
    begin
      wait_for(desc_req_o);
      chk(64'(ready_o), 64'h0, "busy while fetching");
      desc_valid_i <= 1'b1;
      @(posedge core_clk_i);
      desc_valid_i <= 1'b0;
    end
    wait_for(done_o);
  endtask

  // monitor: every completion takes the oldest expectation
  always @(posedge core_clk_i)
  begin
    mis_exp_t e;
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        $display("BAD %0t unexpected completion", $time);
        failures++;
      end
      else
      begin
        e = exp_q.pop_front();
        chk(64'(fault_o), 64'(e.flt), "fault flag");
        if (e.flt)
          chk(64'({fault_kind_o, fault_code_o}), 64'({e.kind, e.code}), "fault kind or code");
        if (e.wr)
          chk({wr_gpr_o, wr_data_o[62:0]}, {1'b1, e.data[62:0]}, "register write");
        if (e.wr)
          chk(64'(wr_data_o[63]), 64'(e.data[63]), "write data top bit");
      end
    end
  end

  initial
  begin
    logic w;
    logic [63:0] r;
    logic [2:0] x;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    mode64_i <= 1'b1;
    // register copies, random width and operand registers
    repeat (4)
    begin
      w = 1'($random(seed));
      r = {$random(seed), $random(seed)};
      x = 3'($random(seed));
      {rex_present_i, register_extension_prefix_bit_i, rex_b_i} <= x;
      issue(OPC_MR, 8'hc1, w, r, ex(1'b0, FLT_NONE, 16'h0, 1'b1, w ? r : r & MASK32), 1'b0);
      chk(64'({dst_hi_byte_o, dst_idx_o}), 64'({x[0], 3'h1}), "destination register");
      chk(64'(size_o), 64'(w ? SZ64 : SZ32), "operand size");
    end
    // extension bit picks an upper register; a prefix hides the high-byte registers
    {rex_present_i, register_extension_prefix_bit_i, rex_b_i} <= 3'b110;
    issue(OPC_RM8, 8'he0, 1'b0, r, ex(1'b0, FLT_NONE, 16'h0, 1'b1, r & MASK8), 1'b0);
    chk(64'({dst_hi_byte_o, dst_idx_o}), 64'h0c, "byte register with prefix");
    // direct offset is cut to the address size and added to the data segment base
    addr_size_i <= SZ16;
    mem_ea_i <= 64'h0001_2345;
    issue(OPC_FD, 8'h00, 1'b0, r, ex(1'b0, FLT_NONE, 16'h0, 1'b1, r & MASK32), 1'b0);
    chk(mem_addr_o, 64'h2345, "direct offset address");
    chk(64'(form_o), 64'(F_FD), "decoded form");
    issue(OPC_TD, 8'h00, 1'b0, r, ex(1'b0, FLT_NONE, 16'h0, 1'b0, 64'h0), 1'b0);
    chk(64'({wr_mem_o, wr_gpr_o}), 64'h2, "store to memory");
    imm_i <= 64'h0000_0000_8000_0012;
    issue(OPC_MI, 8'hc0, 1'b1, 64'h0, ex(1'b0, FLT_NONE, 16'h0, 1'b1, 64'hffff_ffff_8000_0012), 1'b0);
    mode64_i <= 1'b0;
    r = {$random(seed), $random(seed)};
    issue(OPC_SLD, 8'hc0, 1'b0, {r[63:16], 16'h1234}, ex(1'b0, FLT_NONE, 16'h0, 1'b0, 64'h0), 1'b0);
    issue(OPC_SST, 8'hc0, 1'b0, r, ex(1'b0, FLT_NONE, 16'h0, 1'b1, 64'h1234), 1'b0);
    issue(OPC_SLD, 8'hc8, 1'b0, 64'h10, ex(1'b1, FLT_UD, 16'h0, 1'b0, 64'h0), 1'b0);
    prot_mode_i <= 1'b1;
    issue(OPC_SLD, 8'hd0, 1'b0, 64'h3, ex(1'b1, FLT_GP, 16'h0, 1'b0, 64'h0), 1'b0);
    issue(OPC_SLD, 8'hd8, 1'b0, 64'h2, ex(1'b0, FLT_NONE, 16'h0, 1'b0, 64'h0), 1'b0);
    issue(OPC_MR, 8'h00, 1'b0, r, ex(1'b1, FLT_GP, 16'h0, 1'b0, 64'h0), 1'b0);
    // descriptor fields and table base get random values where checks allow
    gdt_base_i <= {$random(seed)} & 32'hffff_fff0;
    ldt_base_i <= $random(seed);
    desc_base_i <= $random(seed);
    desc_limit_i <= 20'($random(seed));
    desc_g_i <= 1'($random(seed));
    issue(OPC_SLD, 8'hd0, 1'b0, 64'h10, ex(1'b0, FLT_NONE, 16'h0, 1'b0, 64'h0), 1'b1);
    chk(64'(desc_addr_o), 64'(gdt_base_i + 32'h10), "descriptor address");
    chk(64'(int_inhibit_o), 64'h1, "inhibit after stack load");
    issue(OPC_SLD, 8'hd0, 1'b0, 64'h10, ex(1'b0, FLT_NONE, 16'h0, 1'b0, 64'h0), 1'b1);
    chk(64'(int_inhibit_o), 64'h0, "inhibit in a run of loads");
    desc_present_i <= 1'b0;
    issue(OPC_SLD, 8'hd8, 1'b0, 64'h13, ex(1'b1, FLT_NP, 16'h0010, 1'b0, 64'h0), 1'b1);
    // let the monitor take the last completion before the verdict
    @(posedge core_clk_i);
    if (exp_q.size() != 0)
    begin
      $display("BAD %0t missing completion", $time);
      failures++;
    end
    close_out();
  end
endmodule
